// >>> src/usb_indirect_register_access.sv
`include "uira_params.svh"

// Overview of operation
// (RULE1) usb registers reachable only via address-select and data-port registers
// (RULE2) bits 5..0 of address-select pick the register the data port acts on
// (RULE3) endpoint select register steers indexed registers to that endpoint
// (RULE4) pending flags: in events at 0x02, out event, common events
// (RULE5) enable registers for the three flag groups at 0x07, 0x09, 0x0b
// (RULE6) frame number low byte at 0x0c, high byte at 0x0d
// (RULE7) with endpoint zero indexed, 0x16 gives its received byte count
// (RULE8) other indexed endpoints: out count low at 0x16, high at 0x17
// (RULE9) indexed out control/status low byte at 0x14, high at 0x15
// (RULE10) 0x11 is endpoint zero csr or in csr low; in csr high at 0x12
// (RULE11) writing one to busy starts indirect read; busy clears when data valid
// (RULE12) auto-read: each data-port read starts the next read at same target
module uira_register_access
   import uira_pkg::*;
#(
   parameter int NUM_EP = 2,
   parameter int EP_SEL_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // processor special function register port
   input wire uira_sfr_req_t sfrReq,
   output logic [7:0] sfrRdata,
   // usb engine status inputs
   input wire uira_events_t events,
   input wire logic [10:0] frameNumber,
   input wire logic [NUM_EP-1:0][15:0] epRxCount,
   input wire logic [7:0] queueRdata,
   // usb engine control outputs
   output logic [6:0] functionAddress,
   output logic [7:0] powerManagement,
   output logic [7:0] inEventEnables,
   output logic [7:0] outEventEnable,
   output logic [7:0] commonEventEnables,
   output logic [7:0] clockRecoveryControl,
   output logic [EP_SEL_W-1:0] endpointSelect,
   output uira_ep_csr_t [NUM_EP-1:0] epCsr,
   // endpoint queue strobes
   output logic queueRead,
   output logic queueWrite,
   output logic queueEp,
   output logic [7:0] queueWdata,
   // pending flags, visible to the engine for its own interrupt path
   output logic [7:0] inEventFlags,
   output logic [7:0] outEventFlag,
   output logic [7:0] commonEventFlags
);

   localparam int SEL_W = (NUM_EP > 1) ? $clog2(NUM_EP) : 1;

   ////////////////////////////////////////////////////////////////////////////
   // state of the access path

   logic busy;
   logic autoRead;
   logic [5:0] targetAddr;
   logic [7:0] dataPort;

   ////////////////////////////////////////////////////////////////////////////
   // processor access decode

   wire sfrHitSel = sfrReq.addr == `UIRA_SFR_ADDR_SEL; // [RULE1]
   wire sfrHitData = sfrReq.addr == `UIRA_SFR_DATA_PORT; // [RULE1]
   wire selWrite = sfrReq.wr && sfrHitSel;
   wire dataWrite = sfrReq.wr && sfrHitData;
   wire dataRead = sfrReq.rd && sfrHitData;

   // a read of the data port re-arms only when auto-read is on
   wire autoStart = dataRead && autoRead; // [RULE12]
   wire busyStart = selWrite && sfrReq.wdata[`UIRA_BUSY_BIT]; // [RULE11]
   wire startRead = busyStart || autoStart;

   // auto-read keeps the target; a select write in the same cycle wins
   wire [5:0] readAddr = selWrite ? sfrReq.wdata[5:0] : targetAddr; // [RULE2]

   ////////////////////////////////////////////////////////////////////////////
   // endpoint index decode

   wire idxValid = endpointSelect < EP_SEL_W'(NUM_EP); // [RULE3]
   wire [SEL_W-1:0] selIdx = endpointSelect[SEL_W-1:0];
   wire uira_ep_csr_t selCsr = idxValid ? epCsr[selIdx] : '0; // [RULE3]
   wire [15:0] selCount = idxValid ? epRxCount[selIdx] : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // read selection of the usb register space

   logic busyCapture;
   logic [5:0] capAddr;

   // one slot serves endpoint zero csr and the in csr low byte of others
   wire [7:0] regValue =
      (capAddr == `UIRA_UA_FUNC_ADDR) ? {1'b0, functionAddress} :
      (capAddr == `UIRA_UA_POWER) ? powerManagement :
      (capAddr == `UIRA_UA_IN_FLAGS) ? inEventFlags : // [RULE4]
      (capAddr == `UIRA_UA_OUT_FLAG) ? outEventFlag : // [RULE4]
      (capAddr == `UIRA_UA_COMMON_FLAGS) ? commonEventFlags : // [RULE4]
      (capAddr == `UIRA_UA_IN_ENABLES) ? inEventEnables : // [RULE5]
      (capAddr == `UIRA_UA_OUT_ENABLE) ? outEventEnable : // [RULE5]
      (capAddr == `UIRA_UA_COMMON_ENABLES) ? commonEventEnables : // [RULE5]
      (capAddr == `UIRA_UA_FRAME_LOW) ? frameNumber[7:0] : // [RULE6]
      (capAddr == `UIRA_UA_FRAME_HIGH) ? {5'h00, frameNumber[10:8]} : // [RULE6]
      (capAddr == `UIRA_UA_EP_SELECT) ? 8'(endpointSelect) :
      (capAddr == `UIRA_UA_CLK_RECOVERY) ? clockRecoveryControl :
      (capAddr == `UIRA_UA_EP_ZERO_CSR) ? selCsr.inLow : // [RULE10]
      (capAddr == `UIRA_UA_EP_IN_CSR_HIGH) ? selCsr.inHigh : // [RULE10]
      (capAddr == `UIRA_UA_EP_OUT_CSR_LOW) ? selCsr.outLow : // [RULE9]
      (capAddr == `UIRA_UA_EP_OUT_CSR_HIGH) ? selCsr.outHigh : // [RULE9]
      (capAddr == `UIRA_UA_COUNT_LOW) ? selCount[7:0] : // [RULE7] [RULE8]
      (capAddr == `UIRA_UA_COUNT_HIGH) ? selCount[15:8] : // [RULE8]
      (capAddr == `UIRA_UA_QUEUE_EP0) ? queueRdata :
      (capAddr == `UIRA_UA_QUEUE_EP1) ? queueRdata :
      8'h00;

   // side effects of an indirect read land in the capture cycle
   wire capQueue = busyCapture &&
      (capAddr == `UIRA_UA_QUEUE_EP0 || capAddr == `UIRA_UA_QUEUE_EP1);
   wire clrIn = busyCapture && capAddr == `UIRA_UA_IN_FLAGS;
   wire clrOut = busyCapture && capAddr == `UIRA_UA_OUT_FLAG;
   wire clrCommon = busyCapture && capAddr == `UIRA_UA_COMMON_FLAGS;

   ////////////////////////////////////////////////////////////////////////////
   // write decode of the usb register space

   // writes go straight to the current target; host waits for busy low first
   // writes to read-only, flag or unmapped targets decode to nothing and are lost
   wire wrFunc = dataWrite && targetAddr == `UIRA_UA_FUNC_ADDR;
   wire wrPower = dataWrite && targetAddr == `UIRA_UA_POWER;
   wire wrInEn = dataWrite && targetAddr == `UIRA_UA_IN_ENABLES;
   wire wrOutEn = dataWrite && targetAddr == `UIRA_UA_OUT_ENABLE;
   wire wrCommonEn = dataWrite && targetAddr == `UIRA_UA_COMMON_ENABLES;
   wire wrSelect = dataWrite && targetAddr == `UIRA_UA_EP_SELECT;
   wire wrClkRec = dataWrite && targetAddr == `UIRA_UA_CLK_RECOVERY;
   wire wrCsrInL = dataWrite && targetAddr == `UIRA_UA_EP_ZERO_CSR;
   wire wrCsrInH = dataWrite && targetAddr == `UIRA_UA_EP_IN_CSR_HIGH;
   wire wrCsrOutL = dataWrite && targetAddr == `UIRA_UA_EP_OUT_CSR_LOW;
   wire wrCsrOutH = dataWrite && targetAddr == `UIRA_UA_EP_OUT_CSR_HIGH;
   wire wrQueue = dataWrite &&
      (targetAddr == `UIRA_UA_QUEUE_EP0 || targetAddr == `UIRA_UA_QUEUE_EP1);

   ////////////////////////////////////////////////////////////////////////////
   // processor read data of the two special function registers

   wire [7:0] selReadValue = {busy, autoRead, targetAddr};
   wire [7:0] next_sfrRdata = sfrHitSel ? selReadValue :
      sfrHitData ? dataPort : 8'h00;

   // registered answer, one cycle after the strobe
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sfrRdata <= 8'h00;
      end else if (sfrReq.rd) begin
         sfrRdata <= next_sfrRdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address select register and busy handshake

   // busy lasts one cycle: the register file answers within that cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         autoRead <= 1'b0;
         targetAddr <= 6'h00;
         busyCapture <= 1'b0;
         capAddr <= 6'h00;
      end else begin
         if (selWrite) begin
            autoRead <= sfrReq.wdata[`UIRA_AUTO_BIT]; // [RULE12]
            targetAddr <= sfrReq.wdata[5:0]; // [RULE2]
         end
         busy <= startRead; // [RULE11]
         busyCapture <= startRead;
         if (startRead) begin
            capAddr <= readAddr;
         end
      end
   end

   // data port takes the addressed register when busy falls
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dataPort <= 8'h00;
      end else if (busyCapture) begin
         dataPort <= regValue; // [RULE11]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pending event flags, cleared by an indirect read

   // a set arriving with the clear survives, so no event is lost
   wire [7:0] next_inFlags = (inEventFlags & ~{8{clrIn}}) | events.inSet;
   wire [7:0] next_outFlag = (outEventFlag & ~{8{clrOut}}) | events.outSet;
   wire [7:0] next_commonFlags = (commonEventFlags & ~{8{clrCommon}}) | events.commonSet;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inEventFlags <= 8'h00;
         outEventFlag <= 8'h00;
         commonEventFlags <= 8'h00;
      end else begin
         inEventFlags <= next_inFlags; // [RULE4]
         outEventFlag <= next_outFlag; // [RULE4]
         commonEventFlags <= next_commonFlags; // [RULE4]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // common writable registers

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         functionAddress <= 7'h00;
         powerManagement <= 8'h00;
         clockRecoveryControl <= `UIRA_CLK_RECOVERY_RESET;
         endpointSelect <= '0;
      end else begin
         if (wrFunc) begin
            functionAddress <= sfrReq.wdata[6:0];
         end
         if (wrPower) begin
            powerManagement <= sfrReq.wdata;
         end
         if (wrClkRec) begin
            clockRecoveryControl <= sfrReq.wdata;
         end
         if (wrSelect) begin
            endpointSelect <= sfrReq.wdata[EP_SEL_W-1:0]; // [RULE3]
         end
      end
   end

   // interrupt enables, handed to the engine's interrupt logic
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inEventEnables <= 8'h00;
         outEventEnable <= 8'h00;
         commonEventEnables <= 8'h00;
      end else begin
         if (wrInEn) begin
            inEventEnables <= sfrReq.wdata; // [RULE5]
         end
         if (wrOutEn) begin
            outEventEnable <= sfrReq.wdata; // [RULE5]
         end
         if (wrCommonEn) begin
            commonEventEnables <= sfrReq.wdata; // [RULE5]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // indexed control and status bytes, one set per endpoint

   // writes with an out-of-range index are dropped rather than aliased
   for (genvar ep = 0; ep < NUM_EP; ep++) begin : g_ep
      wire hitEp = idxValid && selIdx == SEL_W'(ep); // [RULE3]
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            epCsr[ep] <= '0;
         end else if (hitEp) begin
            if (wrCsrInL) begin
               epCsr[ep].inLow <= sfrReq.wdata; // [RULE10]
            end
            if (wrCsrInH) begin
               epCsr[ep].inHigh <= sfrReq.wdata; // [RULE10]
            end
            if (wrCsrOutL) begin
               epCsr[ep].outLow <= sfrReq.wdata; // [RULE9]
            end
            if (wrCsrOutH) begin
               epCsr[ep].outHigh <= sfrReq.wdata; // [RULE9]
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // endpoint queue strobes

   // the queue byte is taken in the capture cycle; the registered pop strobe follows one cycle later
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         queueRead <= 1'b0;
         queueWrite <= 1'b0;
         queueEp <= 1'b0;
         queueWdata <= 8'h00;
      end else begin
         queueRead <= capQueue;
         queueWrite <= wrQueue;
         if (capQueue) begin
            queueEp <= capAddr[0];
         end
         if (wrQueue) begin
            queueEp <= targetAddr[0];
            queueWdata <= sfrReq.wdata;
         end
      end
   end

endmodule : uira_register_access

// >>> src/uira_params.svh
`ifndef UIRA_PARAMS_SVH
`define UIRA_PARAMS_SVH

// processor-side special function register addresses
`define UIRA_SFR_ADDR_SEL 8'h96
`define UIRA_SFR_DATA_PORT 8'h97

// fields of the address select register
`define UIRA_BUSY_BIT 7
`define UIRA_AUTO_BIT 6
`define UIRA_ADDR_SEL_RESET 8'h00

// usb controller register addresses (six-bit target space)
`define UIRA_UA_FUNC_ADDR 6'h00
`define UIRA_UA_POWER 6'h01
`define UIRA_UA_IN_FLAGS 6'h02
`define UIRA_UA_OUT_FLAG 6'h04
`define UIRA_UA_COMMON_FLAGS 6'h06
`define UIRA_UA_IN_ENABLES 6'h07
`define UIRA_UA_OUT_ENABLE 6'h09
`define UIRA_UA_COMMON_ENABLES 6'h0b
`define UIRA_UA_FRAME_LOW 6'h0c
`define UIRA_UA_FRAME_HIGH 6'h0d
`define UIRA_UA_EP_SELECT 6'h0e
`define UIRA_UA_CLK_RECOVERY 6'h0f
`define UIRA_UA_EP_ZERO_CSR 6'h11
`define UIRA_UA_EP_IN_CSR_HIGH 6'h12
`define UIRA_UA_EP_OUT_CSR_LOW 6'h14
`define UIRA_UA_EP_OUT_CSR_HIGH 6'h15
`define UIRA_UA_COUNT_LOW 6'h16
`define UIRA_UA_COUNT_HIGH 6'h17
`define UIRA_UA_QUEUE_EP0 6'h20
`define UIRA_UA_QUEUE_EP1 6'h21

// reset values of the usb registers that are not all zero
`define UIRA_CLK_RECOVERY_RESET 8'h09

`endif

// >>> src/uira_pkg.sv
package uira_pkg;

   // one processor access to the special function register space
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } uira_sfr_req_t;

   // control and status bytes held for one endpoint
   typedef struct packed {
      logic [7:0] inLow;
      logic [7:0] inHigh;
      logic [7:0] outLow;
      logic [7:0] outHigh;
   } uira_ep_csr_t;

   // event pulses from the usb engine, one bit per flag
   typedef struct packed {
      logic [7:0] inSet;
      logic [7:0] outSet;
      logic [7:0] commonSet;
   } uira_events_t;

endpackage : uira_pkg

// >>> testbench/uira_engine_model.sv
module uira_engine_model (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // endpoint queue pop strobe and byte
   input wire logic queueRead,
   output logic [7:0] queueRdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] pops;
   ////////////////////////////////////////////////////////////////
   // every pop moves to a fresh byte, so a stale capture shows up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pops <= 8'h00;
      end else if (queueRead) begin
         pops <= pops + 8'h01;
      end
   end
   assign queueRdata = 8'ha0 + pops;
endmodule : uira_engine_model

// >>> testbench/uira_asserts.sv
module uira_asserts
   import uira_pkg::*;
#(
   parameter int EP_SEL_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // processor port
   input wire uira_sfr_req_t sfrReq,
   input wire logic [7:0] sfrRdata,
   // engine side
   input wire logic [EP_SEL_W-1:0] endpointSelect,
   input wire logic queueRead,
   input wire logic queueWrite,
   input wire logic queueEp,
   input wire logic [7:0] queueWdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] target;
   // decode of the two special function registers
   wire selWr = sfrReq.wr && sfrReq.addr == 8'h96;
   wire datWr = sfrReq.wr && sfrReq.addr == 8'h97;
   wire selRd = sfrReq.rd && sfrReq.addr == 8'h96;
   wire othRd = sfrReq.rd && sfrReq.addr != 8'h96 && sfrReq.addr != 8'h97;
   wire startRd = selWr && sfrReq.wdata[7];
   // shadow of the target field, needed to judge data-port writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         target <= 6'h00;
      end else if (selWr) begin
         target <= sfrReq.wdata[5:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////
   property p_other_rd; othRd |=> sfrRdata == 8'h00; endproperty
   a_other_rd: assert property (p_other_rd) else $error("stray read not zero");
   property p_sel_rd; selRd |=> sfrRdata[5:0] == $past(target); endproperty
   a_sel_rd: assert property (p_sel_rd) else $error("target readback wrong");
   property p_idx_wr;
      datWr && target == 6'h0e |=> endpointSelect == $past(sfrReq.wdata[EP_SEL_W-1:0]);
   endproperty
   a_idx_wr: assert property (p_idx_wr) else $error("index not written");
   property p_q_wr;
      datWr && target[5:1] == 5'h10 |=>
         queueWrite && queueWdata == $past(sfrReq.wdata) && queueEp == $past(target[0]);
   endproperty
   a_q_wr: assert property (p_q_wr) else $error("queue write missing");
   property p_q_wr_cause; queueWrite |-> $past(datWr); endproperty
   a_q_wr_cause: assert property (p_q_wr_cause) else $error("queue write without cause");
   property p_q_rd; startRd && sfrReq.wdata[5:1] == 5'h10 |-> ##[1:2] queueRead; endproperty
   a_q_rd: assert property (p_q_rd) else $error("queue pop missing");
   // an idle cycle between keeps an auto-read or new start from re-arming busy
   property p_busy; startRd ##1 !(sfrReq.rd || sfrReq.wr) ##1 selRd |=> !sfrRdata[7]; endproperty
   a_busy: assert property (p_busy) else $error("busy stuck");
   property p_zero_wr;
      selWr && !sfrReq.wdata[7] ##1 !(sfrReq.rd || sfrReq.wr) ##1 selRd |=> !sfrRdata[7];
   endproperty
   a_zero_wr: assert property (p_zero_wr) else $error("busy set by zero");
   c_auto: cover property (selWr && sfrReq.wdata[6]);
   c_pop: cover property (queueRead);
   c_idx: cover property (datWr && target == 6'h0e);
endmodule : uira_asserts
bind uira_register_access uira_asserts #(.EP_SEL_W(EP_SEL_W)) i_uira_asserts (.clk(clk), .arst_n(arst_n),
   .sfrReq(sfrReq), .sfrRdata(sfrRdata), .endpointSelect(endpointSelect), .queueRead(queueRead),
   .queueWrite(queueWrite), .queueEp(queueEp), .queueWdata(queueWdata));

// >>> testbench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import uira_pkg::*;
   logic clk, arst_n, queueRead, queueWrite, queueEp;
   uira_sfr_req_t sfrReq;
   uira_events_t events;
   uira_ep_csr_t [1:0] epCsr;
   logic [10:0] frameNumber;
   logic [1:0][15:0] epRxCount;
   logic [7:0] sfrRdata, queueRdata, queueWdata, rdata, r;
   logic [3:0] endpointSelect;
   logic [6:0] functionAddress;
   logic [7:0] powerManagement, inEventEnables, outEventEnable, commonEventEnables, clockRecoveryControl;
   logic [7:0] inEventFlags, outEventFlag, commonEventFlags;
   int miscompares, samplesChecked, cycles;
   logic [5:0] rwT[5] = '{6'h00, 6'h01, 6'h07, 6'h09, 6'h0b};
   logic [5:0] csrT[4] = '{6'h11, 6'h12, 6'h14, 6'h15};
   uira_register_access i_uira_register_access (.clk, .arst_n, .sfrReq, .sfrRdata, .events, .frameNumber,
      .epRxCount, .queueRdata, .functionAddress, .powerManagement, .inEventEnables, .outEventEnable,
      .commonEventEnables, .clockRecoveryControl, .endpointSelect, .epCsr, .queueRead, .queueWrite,
      .queueEp, .queueWdata, .inEventFlags, .outEventFlag, .commonEventFlags);
   uira_engine_model i_uira_engine_model (.clk, .arst_n, .queueRead, .queueRdata);
   ////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      samplesChecked++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // expected readback of a common register; the address byte has no bit 7
   function automatic logic [7:0] exp_rw(input logic [5:0] t, input logic [7:0] v);
      return (t == 6'h00) ? (v & 8'h7f) : v;
   endfunction : exp_rw
   // frame high byte carries only the top three bits of the frame number
   function automatic logic [7:0] exp_frame_high(input logic [10:0] f);
      return {5'b00000, f[10:8]};
   endfunction : exp_frame_high
   // seen value of the engine-side port behind a target address
   function automatic logic [7:0] port_of(input logic [5:0] t);
      case (t)
         6'h00: return {1'b0, functionAddress};
         6'h01: return powerManagement;
         6'h02: return inEventFlags;
         6'h04: return outEventFlag;
         6'h06: return commonEventFlags;
         6'h07: return inEventEnables;
         6'h09: return outEventEnable;
         6'h0b: return commonEventEnables;
         6'h0f: return clockRecoveryControl;
         default: return 8'h00;
      endcase
   endfunction : port_of
   // one access held until its taking edge; read answer sampled mid-cycle
   task automatic sfr(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      sfrReq <= '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge clk);
      sfrReq <= '0;
      @(negedge clk);
      rdata = sfrRdata;
   endtask : sfr
   task automatic ind_rd(input logic [5:0] t);
      sfr(8'h96, 1'b1, {2'b10, t});
      sfr(8'h96, 1'b0, 8'h00);
      chk("busy", {2'b00, t}, rdata);
      sfr(8'h97, 1'b0, 8'h00);
   endtask : ind_rd
   task automatic ind_wr(input logic [5:0] t, input logic [7:0] d);
      sfr(8'h96, 1'b1, {2'b00, t});
      sfr(8'h97, 1'b1, d);
   endtask : ind_wr
   ////////////////////////////////////////////////////////////////
   // free-running clock, period 100 ns
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // a hang counts as a failure
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end
   initial begin
      arst_n = 1'b0;
      sfrReq <= '0;
      events <= '0;
      frameNumber <= 11'h000;
      epRxCount <= '0;
      void'($urandom(42));
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      sfr(8'h96, 1'b0, 8'h00);
      chk("selreset", 8'h00, rdata);
      chk("clkrecport", 8'h09, port_of(6'h0f));
      sfr(8'h96, 1'b1, 8'h0f);
      sfr(8'h96, 1'b0, 8'h00);
      chk("zerobusy", 8'h0f, rdata);
      ind_rd(6'h0f);
      chk("clock_recovery_control", 8'h09, rdata);
      sfr(8'h55, 1'b0, 8'h00);
      chk("unmapped", 8'h00, rdata);
      foreach (rwT[i]) begin
         r = 8'($urandom);
         ind_wr(rwT[i], r);
         chk("rwport", exp_rw(rwT[i], r), port_of(rwT[i]));
         ind_rd(rwT[i]);
         chk("rw", exp_rw(rwT[i], r), rdata);
      end
      @(posedge clk);
      frameNumber <= 11'($urandom);
      ind_rd(6'h0c);
      chk("framelow", frameNumber[7:0], rdata);
      ind_rd(6'h0d);
      chk("framehigh", exp_frame_high(frameNumber), rdata);
      // event flags: set by a pulse, cleared by the indirect read
      for (int g = 0; g < 3; g++) begin
         r = 8'($urandom) | 8'h01;
         @(posedge clk);
         events <= uira_events_t'(24'(r) << (16 - 8 * g));
         @(posedge clk);
         events <= '0;
         @(negedge clk);
         chk("flagport", r, port_of(6'(2 + 2 * g)));
         ind_rd(6'(2 + 2 * g));
         chk("flags", r, rdata);
         chk("flagportclr", 8'h00, port_of(6'(2 + 2 * g)));
         ind_rd(6'(2 + 2 * g));
         chk("flagsclear", 8'h00, rdata);
      end
      for (int e = 0; e < 2; e++) begin
         @(posedge clk);
         epRxCount <= {16'($urandom), 16'($urandom)};
         ind_wr(6'h0e, 8'(e));
         chk("index", 8'(e), 8'(endpointSelect));
         ind_rd(6'h16);
         chk("countlow", epRxCount[e][7:0], rdata);
         ind_rd(6'h17);
         chk("counthigh", epRxCount[e][15:8], rdata);
         foreach (csrT[j]) begin
            r = 8'($urandom);
            ind_wr(csrT[j], r);
            chk("csrport", r, 8'(epCsr[e] >> (24 - 8 * j)));
            ind_rd(csrT[j]);
            chk("csr", r, rdata);
         end
      end
      ind_wr(6'h0e, 8'h02);
      ind_rd(6'h11);
      chk("badindex", 8'h00, rdata);
      // auto-read drains successive queue bytes after a single select write that sets busy
      sfr(8'h96, 1'b1, 8'he0);
      for (int n = 0; n < 4; n++) begin
         sfr(8'h97, 1'b0, 8'h00);
         chk("autoread", 8'ha0 + 8'(n), rdata);
      end
      // with auto-read off a second data-port read must not pop again
      ind_rd(6'h20);
      chk("noauto", 8'ha5, rdata);
      sfr(8'h97, 1'b0, 8'h00);
      chk("noauto", 8'ha5, rdata);
      r = 8'($urandom);
      ind_wr(6'h21, r);
      chk("queuewrite", r, queueWdata);
      final_report();
   end
endmodule : tb_top
